// ===== hdl/mpg_pkg.sv
// Function
// - generator enable setting, off after reset
// - interval 10 us to 10 s, 1 us steps
// - modes: free running, start trigger, burst
// - free running pulses continuously while enabled
// - start trigger waits, then pulses continuously
// - burst pulses on trigger until count reached
// - after burst, wait for next trigger
// - timing independent of sensor exposure/readout
// - trigger pacing barred in rolling-illumination modes
// - pulse train selectable as timing-output reference
// - timing output delay 0-10 s, width 1 us-10 s
package mpg_pkg;
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned US_CYCLES    = CLK_MHZ;   // cycles per microsecond
  localparam int unsigned US_W         = 7;
  localparam int unsigned TIME_W       = 24;        // microseconds, up to 10 s
  localparam int unsigned INTERVAL_MIN = 10;        // us
  localparam int unsigned INTERVAL_MAX = 10000000;  // us
  localparam int unsigned DELAY_MAX    = 10000000;  // us
  localparam int unsigned WIDTH_MIN    = 1;         // us
  localparam int unsigned WIDTH_MAX    = 10000000;  // us
  localparam int unsigned COUNT_W      = 16;
  localparam int unsigned REF_W        = 2;
  localparam logic [1:0]  REF_MASTER   = 2'h3;
  localparam logic [US_W-1:0]   US_LAST  = 7'h7c;
  localparam logic [TIME_W-1:0] IVL_MIN  = 24'h00_000a;
  localparam logic [TIME_W-1:0] IVL_MAX  = 24'h98_9680;
  localparam logic [TIME_W-1:0] TIME_MAX = 24'h98_9680;
  localparam logic [TIME_W-1:0] WID_MIN  = 24'h00_0001;

  typedef enum logic [1:0]
  {
    MPG_FREE  = 2'b00,
    MPG_START = 2'b01,
    MPG_BURST = 2'b10
  } mpg_mode_t;

  typedef enum logic [1:0]
  {
    MPG_IDLE = 2'b00,
    MPG_RUN  = 2'b01
  } mpg_state_t;

  typedef enum logic [1:0]
  {
    MPG_PT_IDLE  = 2'b00,
    MPG_PT_DELAY = 2'b01,
    MPG_PT_HIGH  = 2'b10
  } mpg_pt_state_t;
endpackage : mpg_pkg

// ===== hdl/mpg_timing_out.sv
`timescale 1ns/10ps
module mpg_timing_out
  import mpg_pkg::*;
(
  input  wire logic                      core_clk,   // system clock
  input  wire logic                      rst_b,      // async reset, active low
  input  wire logic                      us_tick,    // one-microsecond strobe
  input  wire logic                      ref_event,  // reference event pulse
  input  wire logic [mpg_pkg::TIME_W-1:0] delay_us,  // delay, 0 to 10 s
  input  wire logic [mpg_pkg::TIME_W-1:0] width_us,  // width, 1 us to 10 s
  output logic                           pulse_out   // programmed pulse
);
  import mpg_pkg::*;

  typedef struct packed
  {
    mpg_pt_state_t     st;
    logic [TIME_W-1:0] cnt;
    logic              out;
  } mpg_pt_reg_t;

  mpg_pt_reg_t r;
  mpg_pt_reg_t next_r;
  logic [TIME_W-1:0] dly;
  logic [TIME_W-1:0] wid;

  always_comb
  begin
    // out-of-range settings clamp to the legal span
    dly = (delay_us > TIME_MAX) ? TIME_MAX : delay_us;
    wid = (width_us < WID_MIN) ? WID_MIN :
          ((width_us > TIME_MAX) ? TIME_MAX : width_us);
    next_r = r;
    unique case (r.st)
      MPG_PT_IDLE:
        if (ref_event)
        begin
          next_r.cnt = '0;
          if (dly == '0)
          begin
            next_r.st  = MPG_PT_HIGH;
            next_r.out = 1'b1;
          end
          else
            next_r.st = MPG_PT_DELAY;
        end
      MPG_PT_DELAY:
        if (us_tick)
        begin
          if (r.cnt + 1'b1 >= dly)
          begin
            next_r.cnt = '0;
            next_r.st  = MPG_PT_HIGH;
            next_r.out = 1'b1;
          end
          else
            next_r.cnt = r.cnt + 1'b1;
        end
      MPG_PT_HIGH:
        if (us_tick)
        begin
          if (r.cnt + 1'b1 >= wid)
          begin
            next_r.cnt = '0;
            next_r.st  = MPG_PT_IDLE;
            next_r.out = 1'b0;
          end
          else
            next_r.cnt = r.cnt + 1'b1;
        end
      default:
        next_r = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      r <= '0;
    else
      r <= next_r;
  end

  assign pulse_out = r.out;

  AST_PT_ZERO_DELAY: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_PT_IDLE && ref_event && delay_us == '0) |=> pulse_out)
    else $error("zero delay did not raise the output at once");
endmodule : mpg_timing_out

// ===== hdl/mpg_top.sv
`timescale 1ns/10ps
module mpg_top
  import mpg_pkg::*;
(
  input  wire logic                        core_clk,       // 125 MHz clock
  input  wire logic                        rst_b,          // async reset, active low
  input  wire logic                        gen_enable,     // generator on
  input  wire logic [1:0]                  gen_mode,       // free/start/burst
  input  wire logic [mpg_pkg::TIME_W-1:0]  interval_us,    // pulse interval in us
  input  wire logic [mpg_pkg::COUNT_W-1:0] burst_count,    // pulses per burst
  input  wire logic                        trig_in,        // trigger pin, async
  input  wire logic                        rolling_mode,   // rolling readout active
  input  wire logic                        exp_pace_sel,   // pace exposure by pulses
  input  wire logic [mpg_pkg::REF_W-1:0]   tout_ref_sel,   // timing-output reference
  input  wire logic                        read_end_evt,   // readout-end event
  input  wire logic                        vsync_evt,      // frame start event
  input  wire logic                        hsync_evt,      // line event
  input  wire logic [mpg_pkg::TIME_W-1:0]  tout_delay_us,  // timing-output delay
  input  wire logic [mpg_pkg::TIME_W-1:0]  tout_width_us,  // timing-output width
  output logic                             master_pulse,   // one-cycle pulse
  output logic                             exp_trigger,    // exposure pacing pulse
  output logic                             gen_active,     // sequence running
  output logic                             pace_refused,   // pacing barred
  output logic                             tout_pulse      // timing output
);
  import mpg_pkg::*;

  typedef struct packed
  {
    logic [1:0]         sync;
    logic               trig_d;
    mpg_state_t         st;
    logic [US_W-1:0]    pre;
    logic               tick;
    logic [TIME_W-1:0]  ivl_cnt;
    logic [COUNT_W-1:0] pulses;
    logic               pulse;
    logic               exp;
    logic               active;
    logic               refused;
    logic               ref_evt;
  } mpg_reg_t;

  mpg_reg_t r;
  mpg_reg_t next_r;
  logic [TIME_W-1:0] ivl;
  logic              trig_edge;
  logic              fire;
  logic              tout_q;

  function automatic logic [TIME_W-1:0] mpg_clamp_ivl(input logic [TIME_W-1:0] v);
    if (v < IVL_MIN)
      return IVL_MIN;
    else if (v > IVL_MAX)
      return IVL_MAX;
    else
      return v;
  endfunction : mpg_clamp_ivl

  always_comb
  begin
    next_r = r;
    ivl = mpg_clamp_ivl(interval_us);
    // the second sync stage feeds the edge detector, never the first
    next_r.sync   = {r.sync[0], trig_in};
    next_r.trig_d = r.sync[1];
    trig_edge     = r.sync[1] & ~r.trig_d;
    // free microsecond prescaler: no sensor timing is consulted
    next_r.tick = 1'b0;
    if (r.pre == US_LAST)
    begin
      next_r.pre  = '0;
      next_r.tick = 1'b1;
    end
    else
      next_r.pre = r.pre + 1'b1;
    fire = 1'b0;
    next_r.pulse = 1'b0;
    unique case (r.st)
      MPG_IDLE:
      begin
        next_r.ivl_cnt = '0;
        if (gen_enable)
        begin
          if (gen_mode == MPG_FREE)
            next_r.st = MPG_RUN;
          else if ((gen_mode == MPG_START || gen_mode == MPG_BURST) && trig_edge)
          begin
            next_r.st = MPG_RUN;
            next_r.pulses = '0;
          end
        end
      end
      MPG_RUN:
      begin
        // triggers are not looked at here, so a repeat is ignored
        if (!gen_enable)
          next_r.st = MPG_IDLE;
        else if (gen_mode == MPG_FREE && r.active == 1'b0)
          next_r.st = MPG_RUN;
        else if (r.tick)
        begin
          if (r.ivl_cnt == '0)
            fire = 1'b1;
          if (r.ivl_cnt + 1'b1 >= ivl)
            next_r.ivl_cnt = '0;
          else
            next_r.ivl_cnt = r.ivl_cnt + 1'b1;
        end
        if (fire)
        begin
          next_r.pulse = 1'b1;
          if (gen_mode == MPG_BURST)
          begin
            next_r.pulses = r.pulses + 1'b1;
            if (r.pulses + 1'b1 >= burst_count)
              next_r.st = MPG_IDLE;
          end
        end
      end
      default:
        next_r.st = MPG_IDLE;
    endcase
    next_r.active  = (next_r.st == MPG_RUN);
    next_r.refused = exp_pace_sel & rolling_mode;
    next_r.exp     = fire & exp_pace_sel & ~rolling_mode;
    unique case (tout_ref_sel)
      2'h0:       next_r.ref_evt = read_end_evt;
      2'h1:       next_r.ref_evt = vsync_evt;
      2'h2:       next_r.ref_evt = hsync_evt;
      REF_MASTER: next_r.ref_evt = fire;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      r <= '0;
    else
      r <= next_r;
  end

  mpg_timing_out u_tout
  (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .us_tick   (r.tick),
    .ref_event (r.ref_evt),
    .delay_us  (tout_delay_us),
    .width_us  (tout_width_us),
    .pulse_out (tout_q)
  );

  assign master_pulse = r.pulse;
  assign exp_trigger  = r.exp;
  assign gen_active   = r.active;
  assign pace_refused = r.refused;
  assign tout_pulse   = tout_q;

  AST_OFF_NO_PULSE: assert property (@(posedge core_clk) disable iff (!rst_b)
    !gen_enable |=> !master_pulse)
    else $error("pulse while generator off");

  AST_TICK_PERIOD: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.tick |=> !r.tick [*8])
    else $error("microsecond tick came too soon");

  AST_PULSE_SPACING: assert property (@(posedge core_clk) disable iff (!rst_b)
    master_pulse |=> !master_pulse [*8])
    else $error("pulses closer than the minimum interval");

  AST_FREE_START: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_IDLE && gen_enable && gen_mode == MPG_FREE) |=> gen_active)
    else $error("free running did not start");

  AST_START_WAITS: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_IDLE && gen_mode == MPG_START && !trig_edge) |=> !gen_active)
    else $error("start mode ran without a trigger");

  AST_BURST_END: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_RUN && gen_enable && gen_mode == MPG_BURST && fire
     && r.pulses + 1'b1 >= burst_count) |=> (!gen_active ##1 !master_pulse))
    else $error("burst did not stop at its count");

  AST_BURST_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_IDLE && gen_enable && gen_mode == MPG_BURST && trig_edge)
    |=> (r.pulses == '0 && gen_active))
    else $error("burst count not cleared at start");

  AST_PACE_BAR: assert property (@(posedge core_clk) disable iff (!rst_b)
    rolling_mode |=> !exp_trigger)
    else $error("exposure paced in rolling mode");

  AST_REF_MASTER: assert property (@(posedge core_clk) disable iff (!rst_b)
    (tout_ref_sel == REF_MASTER && fire) |=> r.ref_evt)
    else $error("master pulse not passed as reference");

  AST_EXP_NEEDS_PULSE: assert property (@(posedge core_clk) disable iff (!rst_b)
    exp_trigger |-> master_pulse)
    else $error("exposure pulse without a master pulse");

  AST_PACE_PASS: assert property (@(posedge core_clk) disable iff (!rst_b)
    (fire && exp_pace_sel && !rolling_mode) |=> exp_trigger)
    else $error("paced exposure pulse missing");

  AST_PACE_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
    !exp_pace_sel |=> !exp_trigger)
    else $error("exposure paced while pacing is off");

  AST_REFUSED_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
    (exp_pace_sel && rolling_mode) |=> pace_refused)
    else $error("barred pacing not flagged");

  AST_REFUSED_CLR: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(exp_pace_sel && rolling_mode) |=> !pace_refused)
    else $error("pacing flagged as barred without cause");

  AST_FIRE_PULSE: assert property (@(posedge core_clk) disable iff (!rst_b)
    fire |=> master_pulse)
    else $error("interval elapsed without a pulse");

  AST_NO_FIRE_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
    !fire |=> !master_pulse)
    else $error("pulse without an elapsed interval");

  AST_FIRE_ON_TICK: assert property (@(posedge core_clk) disable iff (!rst_b)
    fire |-> r.tick)
    else $error("pulse off the microsecond grid");

  AST_TICK_DUE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.pre == US_LAST) |=> r.tick)
    else $error("microsecond tick missing");

  AST_TICK_ONLY_LAST: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.pre != US_LAST) |=> !r.tick)
    else $error("microsecond tick out of place");

  AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_IDLE) |=> !master_pulse)
    else $error("pulse while waiting");

  AST_ACTIVE_STATE: assert property (@(posedge core_clk) disable iff (!rst_b)
    gen_active == (r.st == MPG_RUN))
    else $error("active flag disagrees with the sequencer");

  AST_RUN_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_RUN && gen_enable && !fire) |=> gen_active)
    else $error("running sequence stopped without cause");

  AST_FREE_NO_END: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_RUN && gen_enable && gen_mode == MPG_FREE) |=> gen_active)
    else $error("free running stopped while enabled");

  AST_START_NO_END: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_RUN && gen_enable && gen_mode == MPG_START) |=> gen_active)
    else $error("started train stopped while enabled");

  AST_DISABLE_STOP: assert property (@(posedge core_clk) disable iff (!rst_b)
    !gen_enable |=> !gen_active)
    else $error("generator active while off");

  AST_MODE3_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_IDLE && gen_mode == 2'h3) |=> !gen_active)
    else $error("unused mode code started the generator");

  AST_BURST_WAITS: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_IDLE && gen_mode == MPG_BURST && !trig_edge) |=> !gen_active)
    else $error("burst started without a trigger");

  AST_TRIG_START: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_IDLE && gen_enable && gen_mode == MPG_START && trig_edge) |=> gen_active)
    else $error("trigger did not start the train");

  AST_SYNC_EDGE: assert property (@(posedge core_clk) disable iff (!rst_b)
    trig_edge |=> !trig_edge)
    else $error("one trigger edge seen twice");

  AST_REF_READ_END: assert property (@(posedge core_clk) disable iff (!rst_b)
    (tout_ref_sel == 2'h0 && read_end_evt) |=> r.ref_evt)
    else $error("readout-end reference lost");

  AST_REF_VSYNC: assert property (@(posedge core_clk) disable iff (!rst_b)
    (tout_ref_sel == 2'h1 && vsync_evt) |=> r.ref_evt)
    else $error("frame start reference lost");

  AST_REF_HSYNC: assert property (@(posedge core_clk) disable iff (!rst_b)
    (tout_ref_sel == 2'h2 && hsync_evt) |=> r.ref_evt)
    else $error("line reference lost");

  AST_REF_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
    (tout_ref_sel == REF_MASTER && !fire) |=> !r.ref_evt)
    else $error("reference event without a master pulse");

  AST_IVL_PASS: assert property (@(posedge core_clk) disable iff (!rst_b)
    (interval_us >= IVL_MIN && interval_us <= IVL_MAX) |-> (ivl == interval_us))
    else $error("legal interval altered");

  AST_IVL_LOW: assert property (@(posedge core_clk) disable iff (!rst_b)
    (interval_us < IVL_MIN) |-> (ivl == IVL_MIN))
    else $error("short interval not raised to the minimum");

  AST_IVL_HIGH: assert property (@(posedge core_clk) disable iff (!rst_b)
    (interval_us > IVL_MAX) |-> (ivl == IVL_MAX))
    else $error("long interval not cut to the maximum");

  AST_CNT_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (r.st == MPG_IDLE) |=> (r.ivl_cnt == '0))
    else $error("interval count not cleared while waiting");
endmodule : mpg_top

// ===== verification/mpg_far_side.sv
`timescale 1ns/10ps
module mpg_far_side
(
  input  wire logic core_clk,      // system clock
  output logic      trig_in,       // trigger pin
  output logic      read_end_evt,  // readout-end pulse
  output logic      vsync_evt,     // frame start pulse
  output logic      hsync_evt      // line pulse
);
  initial
  begin
    trig_in      = 1'b0;
    read_end_evt = 1'b0;
    vsync_evt    = 1'b0;
    hsync_evt    = 1'b0;
  end

  // held six cycles so the two-flop synchroniser cannot miss the edge
  task automatic send_trig();
    @(posedge core_clk);
    trig_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    trig_in <= 1'b0;
  endtask : send_trig

  task automatic send_evt(input logic [1:0] sel);
    @(posedge core_clk);
    read_end_evt <= (sel == 2'h0);
    vsync_evt    <= (sel == 2'h1);
    hsync_evt    <= (sel == 2'h2);
    @(posedge core_clk);
    {read_end_evt, vsync_evt, hsync_evt} <= 3'h0;
  endtask : send_evt
endmodule : mpg_far_side

// ===== verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  import mpg_pkg::*;
  logic               core_clk, rst_b, gen_enable, trig_in, rolling_mode, exp_pace_sel;
  logic               read_end_evt, vsync_evt, hsync_evt;
  logic               master_pulse, exp_trigger, gen_active, pace_refused, tout_pulse;
  logic [1:0]         gen_mode;
  logic [REF_W-1:0]   tout_ref_sel;
  logic [COUNT_W-1:0] burst_count;
  logic [TIME_W-1:0]  interval_us, tout_delay_us, tout_width_us;
  logic [TIME_W-1:0]  ivl [4] = '{24'h00_000a, 24'h00_0003, 24'h00_000b, 24'h00_0009};
  int                 gap [4] = '{1250, 1250, 1375, 1250};
  int                 error_cnt = 0;
  int                 checked = 0;
  int                 n, m;

  mpg_top DUT (.core_clk, .rst_b, .gen_enable, .gen_mode, .interval_us, .burst_count,
    .trig_in, .rolling_mode, .exp_pace_sel, .tout_ref_sel, .read_end_evt, .vsync_evt,
    .hsync_evt, .tout_delay_us, .tout_width_us, .master_pulse, .exp_trigger, .gen_active,
    .pace_refused, .tout_pulse);
  mpg_far_side far (.core_clk, .trig_in, .read_end_evt, .vsync_evt, .hsync_evt);

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("errors %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // cycles until master pulse (sel 0) or timing output is high (1) or low (2)
  task automatic wait_hi(input int sel, input int lim, output int cnt);
    for (cnt = 1; cnt <= lim; cnt++)
    begin
      @(posedge core_clk);
      if (sel == 0 ? master_pulse === 1'b1 : (tout_pulse === 1'b1) == (sel == 1))
        return;
    end
    check(32'h0000_0000, 32'h0000_0001);
  endtask : wait_hi

  task automatic count(input int cycles, output int mp, output int ex);
    mp = 0;
    ex = 0;
    repeat (cycles)
    begin
      @(posedge core_clk);
      mp += (master_pulse === 1'b1);
      ex += (exp_trigger === 1'b1);
    end
  endtask : count

  // a pause with the generator off so every run starts from idle
  task automatic start(input logic [1:0] mode, input logic [TIME_W-1:0] iv);
    gen_enable  <= 1'b0;
    gen_mode    <= mode;
    interval_us <= iv;
    repeat (3) @(posedge core_clk);
    gen_enable  <= 1'b1;
    @(posedge core_clk);
  endtask : start

  task automatic burst(input int exp_n, input bit retrig);
    int pulses;
    bit up;
    pulses = 0;
    up     = 0;
    fork far.send_trig(); join_none
    repeat (6000)
    begin
      @(posedge core_clk);
      pulses += (master_pulse === 1'b1);
      up |= (gen_active === 1'b1);
      if (retrig && pulses == 2 && master_pulse === 1'b1)
        fork far.send_trig(); join_none
      if (up && gen_active !== 1'b1)
        break;
    end
    check(pulses, exp_n);
    check(gen_active, 0);
  endtask : burst

  initial
  begin
    rst_b = 1'b0; gen_enable = 1'b0; gen_mode = 2'h0; interval_us = 24'h00_000a;
    burst_count = 16'h0003; rolling_mode = 1'b0; exp_pace_sel = 1'b0;
    tout_ref_sel = 2'h0; tout_delay_us = 24'h00_0004; tout_width_us = 24'h00_0002;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    count(300, n, m);
    check(n, 0);
    check(gen_active, 0);
    foreach (ivl[i])
    begin
      start(MPG_FREE, ivl[i]);
      wait_hi(0, 200, n);
      wait_hi(0, 2000, n);
      check(n, gap[i]);
    end
    exp_pace_sel <= 1'b1;
    wait_hi(0, 1300, n);
    repeat (5) @(posedge core_clk);
    count(2500, n, m);
    check(n, 2);
    check(m, 2);
    check(pace_refused, 0);
    rolling_mode <= 1'b1;
    repeat (5) @(posedge core_clk);
    check(pace_refused, 1);
    count(2500, n, m);
    check(m, 0);
    check(n, 2);
    rolling_mode <= 1'b0;
    exp_pace_sel <= 1'b0;
    gen_enable   <= 1'b0;
    repeat (2) @(posedge core_clk);
    count(1500, n, m);
    check(n, 0);
    start(2'h3, 24'h00_000a);
    far.send_trig();
    count(1500, n, m);
    check(n, 0);
    start(MPG_START, 24'h00_000a);
    count(1500, n, m);
    check(n, 0);
    far.send_trig();
    check(gen_active, 1);
    wait_hi(0, 1400, n);
    wait_hi(0, 2000, n);
    check(n, 1250);
    start(MPG_BURST, 24'h00_000a);
    burst(3, 1'b1);
    count(1500, n, m);
    check(n, 0);
    burst(3, 1'b0);
    burst_count <= 16'h0001;
    burst(1, 1'b0);
    for (int s = 0; s < 3; s++)
    begin
      tout_ref_sel <= s[1:0];
      fork far.send_evt(s[1:0]); join_none
      wait_hi(1, 1000, n);
      check(n >= 370 && n <= 630, 1);
      wait_hi(2, 1000, n);
      check(n >= 124 && n <= 380, 1);
    end
    tout_ref_sel  <= REF_MASTER;
    tout_delay_us <= 24'h00_0000;
    start(MPG_FREE, 24'h00_000a);
    wait_hi(0, 200, n);
    wait_hi(1, 200, m);
    check(m <= 130, 1);
    stop_test();
  end

  // the sequence needs about 30000 cycles; twice that means a hang
  initial
  begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end
endmodule : testbench
